//--- verilog/bsc_boot_serial.sv
// Serial programming mode interpreter: baud detection, emulation and security commands
`timescale 1ns/10ps
`default_nettype none

module bsc_boot_serial #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Serial link pins
    input wire logic serial_rx_in,
    output logic serial_tx_out,
    // Flash security checker
    input wire logic flash_blank_in,
    input wire logic [7:0] pw_len_in,
    input wire logic pw_match_in,
    output logic [23:0] count_addr_out,
    output logic [23:0] cmp_addr_out,
    output logic [7:0] pw_byte_out,
    output logic pw_byte_valid_out,
    output logic pw_check_out,
    output logic security_set_out,
    // Link status
    output logic link_idle_out
);

    initial begin
        if (CNT_W < 8 || CNT_W > 28) begin
            $error("bsc_boot_serial: CNT_W must lie in 8..28");
        end
    end

    localparam logic [CNT_W-1:0] CNT_MAX = '1;
    localparam logic [CNT_W-1:0] HIGH_MIN = CNT_W'(bsc_pkg::MIN_HIGH);

    bsc_pkg::bsc_state_type state;

    // Pin synchroniser, first stage is the only reader of the pin; logic uses the second stage onward
    logic rx_meta;
    logic rx_sync;
    logic rx_prev;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
            rx_prev <= 1'b1;
        end else begin
            rx_meta <= serial_rx_in;
            rx_sync <= rx_meta;
            rx_prev <= rx_sync;
        end
    end

    // Baud detection results
    logic [CNT_W-1:0] ab_cnt;
    logic [CNT_W-1:0] ab_low;
    logic [CNT_W+1:0] ab_tail;
    logic [CNT_W-1:0] bit_len;
    logic [7:0] ab_byte;
    logic rx_en;
    logic [CNT_W+1:0] h_ext;
    logic [CNT_W+1:0] l_ext;

    assign h_ext = {2'b00, ab_cnt};
    assign l_ext = {2'b00, ab_low};
    assign rx_en = (state != bsc_pkg::ST_AB_WAIT) && (state != bsc_pkg::ST_AB_LOW)
        && (state != bsc_pkg::ST_AB_HIGH) && (state != bsc_pkg::ST_AB_TAIL);

    // Receiver at the detected rate
    logic rx_busy;
    logic [CNT_W-1:0] rx_tick;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_done;
    logic rx_ferr;

    always_ff @(posedge core_clk_in) begin
        if (rst_in || !rx_en) begin
            rx_busy <= 1'b0;
            rx_tick <= '0;
            rx_bit <= 4'h0;
            rx_sh <= 8'h00;
            rx_done <= 1'b0;
            rx_ferr <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            if (!rx_busy) begin
                if (rx_prev && !rx_sync) begin
                    rx_busy <= 1'b1;
                    rx_tick <= bit_len >> 1;
                    rx_bit <= 4'h0;
                end
            end else if (rx_tick != '0) begin
                rx_tick <= rx_tick - 1'b1;
            end else begin
                rx_tick <= bit_len - 1'b1;
                if (rx_bit == 4'h0 && rx_sync) begin
                    // Glitch, not a start bit
                    rx_busy <= 1'b0;
                end else if (rx_bit == bsc_pkg::FRAME_LAST) begin
                    rx_busy <= 1'b0;
                    rx_done <= 1'b1;
                    rx_ferr <= !rx_sync;
                end else begin
                    if (rx_bit != 4'h0) begin
                        rx_sh <= {rx_sync, rx_sh[7:1]};
                    end
                    rx_bit <= rx_bit + 4'h1;
                end
            end
        end
    end

    // Transmitter at the detected rate, repeats a byte up to three times
    logic tx_load;
    logic [7:0] tx_load_byte;
    logic [1:0] tx_load_rep;
    logic tx_busy;
    logic tx_active;
    logic [7:0] tx_byte;
    logic [1:0] tx_left;
    logic [9:0] tx_sh;
    logic [3:0] tx_bit;
    logic [CNT_W-1:0] tx_tick;

    assign tx_active = tx_busy || tx_load;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            tx_busy <= 1'b0;
            tx_byte <= 8'h00;
            tx_left <= 2'h0;
            tx_sh <= 10'h3FF;
            tx_bit <= 4'h0;
            tx_tick <= '0;
            serial_tx_out <= 1'b1;
        end else begin
            serial_tx_out <= tx_busy ? tx_sh[0] : 1'b1;
            if (tx_load) begin
                tx_busy <= 1'b1;
                tx_byte <= tx_load_byte;
                tx_left <= tx_load_rep - 2'h1;
                tx_sh <= {1'b1, tx_load_byte, 1'b0};
                tx_bit <= 4'h0;
                tx_tick <= bit_len - 1'b1;
            end else if (tx_busy) begin
                if (tx_tick != '0) begin
                    tx_tick <= tx_tick - 1'b1;
                end else begin
                    tx_tick <= bit_len - 1'b1;
                    if (tx_bit == bsc_pkg::FRAME_LAST) begin
                        if (tx_left != 2'h0) begin
                            tx_left <= tx_left - 2'h1;
                            tx_sh <= {1'b1, tx_byte, 1'b0};
                            tx_bit <= 4'h0;
                        end else begin
                            tx_busy <= 1'b0;
                        end
                    end else begin
                        tx_sh <= {1'b1, tx_sh[9:1]};
                        tx_bit <= tx_bit + 4'h1;
                    end
                end
            end
        end
    end

    // One byte holding stage; a second byte before the first is taken is an overrun
    logic pend;
    logic [7:0] pend_data;
    logic pend_ferr;
    logic pend_ovr;
    logic take;

    assign take = pend && !tx_active && (state >= bsc_pkg::ST_MATCH2)
        && (state <= bsc_pkg::ST_PW);

    always_ff @(posedge core_clk_in) begin
        if (rst_in || !rx_en) begin
            pend <= 1'b0;
            pend_data <= 8'h00;
            pend_ferr <= 1'b0;
            pend_ovr <= 1'b0;
        end else if (rx_done) begin
            pend <= 1'b1;
            pend_data <= rx_sh;
            pend_ferr <= rx_ferr;
            pend_ovr <= (pend || pend_ovr) && !take;
        end else if (take) begin
            pend <= 1'b0;
            pend_ovr <= 1'b0;
        end
    end

    // Command sequencer
    logic [47:0] addr_sh;
    logic [2:0] addr_idx;
    logic [7:0] pw_left;
    logic byte_bad;

    assign byte_bad = pend_ferr || pend_ovr;
    assign pw_check_out = (state == bsc_pkg::ST_CHECK);
    // Idle only once the triple error code has fully left the pin
    assign link_idle_out = (state == bsc_pkg::ST_DEAD) && !tx_active;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            state <= bsc_pkg::ST_AB_WAIT;
            ab_cnt <= '0;
            ab_low <= '0;
            ab_tail <= '0;
            ab_byte <= 8'h00;
            bit_len <= CNT_MAX;
            tx_load <= 1'b0;
            tx_load_byte <= 8'h00;
            tx_load_rep <= bsc_pkg::ONE_SHOT;
            addr_sh <= 48'h0;
            addr_idx <= 3'h0;
            pw_left <= 8'h00;
            count_addr_out <= 24'h000000;
            cmp_addr_out <= 24'h000000;
            pw_byte_out <= 8'h00;
            pw_byte_valid_out <= 1'b0;
            security_set_out <= 1'b0;
        end else begin
            tx_load <= 1'b0;
            tx_load_rep <= bsc_pkg::ONE_SHOT;
            pw_byte_valid_out <= 1'b0;
            security_set_out <= 1'b0;
            case (state)
                bsc_pkg::ST_AB_WAIT: begin
                    if (rx_prev && !rx_sync) begin
                        ab_cnt <= CNT_W'(1);
                        state <= bsc_pkg::ST_AB_LOW;
                    end
                end
                bsc_pkg::ST_AB_LOW: begin
                    if (rx_sync) begin
                        ab_low <= ab_cnt;
                        ab_cnt <= CNT_W'(1);
                        state <= bsc_pkg::ST_AB_HIGH;
                    end else if (ab_cnt == CNT_MAX) begin
                        state <= bsc_pkg::ST_AB_WAIT;
                    end else begin
                        ab_cnt <= ab_cnt + 1'b1;
                    end
                end
                bsc_pkg::ST_AB_HIGH: begin
                    // Both matching bytes show a two-bit high run; the low run tells them apart
                    if (!rx_sync) begin
                        bit_len <= ab_cnt >> 1;
                        if (ab_cnt < HIGH_MIN) begin
                            state <= bsc_pkg::ST_AB_WAIT;
                        end else if (l_ext < h_ext + (h_ext >> 1) + (h_ext >> 2)) begin
                            ab_byte <= bsc_pkg::MATCH1_A;
                            ab_tail <= (h_ext << 1) + (h_ext >> 1) + (h_ext >> 2);
                            state <= bsc_pkg::ST_AB_TAIL;
                        end else if (l_ext < (h_ext << 1) + h_ext + (h_ext >> 2)) begin
                            ab_byte <= bsc_pkg::MATCH1_B;
                            ab_tail <= h_ext + (h_ext >> 2);
                            state <= bsc_pkg::ST_AB_TAIL;
                        end else begin
                            state <= bsc_pkg::ST_AB_WAIT;
                        end
                    end else if (ab_cnt == CNT_MAX) begin
                        state <= bsc_pkg::ST_AB_WAIT;
                    end else begin
                        ab_cnt <= ab_cnt + 1'b1;
                    end
                end
                bsc_pkg::ST_AB_TAIL: begin
                    // Sample the stop bit mid-way; a low line means no valid matching byte
                    if (ab_tail != '0) begin
                        ab_tail <= ab_tail - 1'b1;
                    end else if (rx_sync) begin
                        tx_load <= 1'b1;
                        tx_load_byte <= ab_byte;
                        state <= bsc_pkg::ST_MATCH2;
                    end else begin
                        state <= bsc_pkg::ST_AB_WAIT;
                    end
                end
                bsc_pkg::ST_MATCH2: begin
                    if (take) begin
                        if (!byte_bad && (pend_data == bsc_pkg::MATCH2_A
                                || pend_data == bsc_pkg::MATCH2_B)) begin
                            tx_load <= 1'b1;
                            tx_load_byte <= pend_data;
                            state <= bsc_pkg::ST_CMD;
                        end else begin
                            state <= bsc_pkg::ST_DEAD;
                        end
                    end
                end
                bsc_pkg::ST_CMD: begin
                    if (take) begin
                        tx_load <= 1'b1;
                        if (pend_ferr) begin
                            tx_load_byte <= bsc_pkg::ERR_FRAME;
                            tx_load_rep <= bsc_pkg::ERR_REPEAT;
                            state <= bsc_pkg::ST_DEAD;
                        end else if (pend_ovr) begin
                            tx_load_byte <= bsc_pkg::ERR_OVR;
                            tx_load_rep <= bsc_pkg::ERR_REPEAT;
                            state <= bsc_pkg::ST_DEAD;
                        end else if (pend_data == bsc_pkg::CMD_EMU) begin
                            tx_load_byte <= bsc_pkg::CMD_EMU;
                            state <= bsc_pkg::ST_EMU_VAL;
                        end else if (pend_data == bsc_pkg::CMD_SEC) begin
                            tx_load_byte <= bsc_pkg::CMD_SEC;
                            addr_idx <= 3'h0;
                            state <= bsc_pkg::ST_ADDR;
                        end else begin
                            tx_load_byte <= bsc_pkg::ERR_CMD;
                            tx_load_rep <= bsc_pkg::ERR_REPEAT;
                            state <= bsc_pkg::ST_DEAD;
                        end
                    end
                end
                bsc_pkg::ST_EMU_VAL: begin
                    // Set value is taken and dropped on this part
                    if (take) begin
                        if (!byte_bad) begin
                            tx_load <= 1'b1;
                            tx_load_byte <= bsc_pkg::EMU_DONE;
                            state <= bsc_pkg::ST_CMD;
                        end else begin
                            state <= bsc_pkg::ST_DEAD;
                        end
                    end
                end
                bsc_pkg::ST_ADDR: begin
                    if (take) begin
                        if (byte_bad) begin
                            state <= bsc_pkg::ST_DEAD;
                        end else begin
                            addr_sh <= {addr_sh[39:0], pend_data};
                            addr_idx <= addr_idx + 3'h1;
                            if (addr_idx == bsc_pkg::ADDR_LAST) begin
                                count_addr_out <= addr_sh[39:16];
                                cmp_addr_out <= {addr_sh[15:0], pend_data};
                                state <= bsc_pkg::ST_LEN;
                            end
                        end
                    end
                end
                bsc_pkg::ST_LEN: begin
                    pw_left <= pw_len_in;
                    state <= (pw_len_in == 8'h00) ? bsc_pkg::ST_PW_END : bsc_pkg::ST_PW;
                end
                bsc_pkg::ST_PW: begin
                    if (take) begin
                        if (byte_bad) begin
                            state <= bsc_pkg::ST_DEAD;
                        end else begin
                            pw_byte_out <= pend_data;
                            pw_byte_valid_out <= 1'b1;
                            pw_left <= pw_left - 8'h01;
                            if (pw_left == 8'h01) begin
                                state <= bsc_pkg::ST_PW_END;
                            end
                        end
                    end
                end
                bsc_pkg::ST_PW_END: begin
                    // Gives the checker a cycle after the last string byte
                    state <= bsc_pkg::ST_CHECK;
                end
                bsc_pkg::ST_CHECK: begin
                    if (!flash_blank_in && pw_match_in) begin
                        tx_load <= 1'b1;
                        tx_load_byte <= bsc_pkg::SEC_DONE;
                        security_set_out <= 1'b1;
                        state <= bsc_pkg::ST_CMD;
                    end else begin
                        state <= bsc_pkg::ST_DEAD;
                    end
                end
                bsc_pkg::ST_DEAD: begin
                    // Only a reset leaves this state
                    state <= bsc_pkg::ST_DEAD;
                end
                default: begin
                    state <= bsc_pkg::ST_DEAD;
                end
            endcase
        end
    end

endmodule : bsc_boot_serial

`default_nettype wire

//--- verilog/bsc_pkg.sv
// Constants and types for the serial boot security command interpreter
package bsc_pkg;

    // First and second matching bytes
    localparam logic [7:0] MATCH1_A = 8'h86;
    localparam logic [7:0] MATCH1_B = 8'h30;
    localparam logic [7:0] MATCH2_A = 8'h79;
    localparam logic [7:0] MATCH2_B = 8'hCF;

    // Operation commands and completion bytes
    localparam logic [7:0] CMD_EMU = 8'hD0;
    localparam logic [7:0] EMU_DONE = 8'hD1;
    localparam logic [7:0] CMD_SEC = 8'hFA;
    localparam logic [7:0] SEC_DONE = 8'hFB;

    // Error codes and how often each is sent
    localparam logic [7:0] ERR_CMD = 8'h63;
    localparam logic [7:0] ERR_FRAME = 8'hA1;
    localparam logic [7:0] ERR_OVR = 8'hA3;
    localparam logic [1:0] ERR_REPEAT = 2'h3;
    localparam logic [1:0] ONE_SHOT = 2'h1;

    // Address bytes after the security command: count address, then compare address
    localparam logic [2:0] ADDR_LAST = 3'h5;

    // Shortest accepted high run of a matching byte, in clocks (two bit times)
    localparam int MIN_HIGH = 8;

    // Serial frame: start, eight data, stop
    localparam logic [3:0] FRAME_LAST = 4'h9;

    typedef enum logic [3:0] {
        ST_AB_WAIT,
        ST_AB_LOW,
        ST_AB_HIGH,
        ST_AB_TAIL,
        ST_MATCH2,
        ST_CMD,
        ST_EMU_VAL,
        ST_ADDR,
        ST_LEN,
        ST_PW,
        ST_PW_END,
        ST_CHECK,
        ST_DEAD
    } bsc_state_type;

endpackage : bsc_pkg

//--- verification/bsc_boot_serial_sva.sv
// Port-level assertions for the serial boot security interpreter
`timescale 1ns/10ps
`default_nettype none

module bsc_boot_serial_sva #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Serial link pins
    input wire logic serial_rx_in,
    input wire logic serial_tx_out,
    // Flash security checker
    input wire logic flash_blank_in,
    input wire logic [7:0] pw_len_in,
    input wire logic pw_match_in,
    input wire logic [23:0] count_addr_out,
    input wire logic [23:0] cmp_addr_out,
    input wire logic [7:0] pw_byte_out,
    input wire logic pw_byte_valid_out,
    input wire logic pw_check_out,
    input wire logic security_set_out,
    // Link status
    input wire logic link_idle_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);

    chk_idle_sticky: assert property (link_idle_out |=> link_idle_out)
        else $error("idle state left without reset");
    // Reset itself is the antecedent, so this one may not be disabled by it
    chk_reset_quiet: assert property (disable iff (1'h0) rst_in |=> serial_tx_out && !link_idle_out)
        else $error("outputs not quiet after reset");
    chk_set_match: assert property (pw_check_out && pw_match_in && !flash_blank_in |=> security_set_out)
        else $error("accepted password not signalled");
    chk_fail_idle: assert property ((pw_check_out && (!pw_match_in || flash_blank_in)) |=> !security_set_out ##[0:2] link_idle_out)
        else $error("failed check did not idle");
    chk_set_cause: assert property (security_set_out |-> $past(pw_check_out) && !link_idle_out)
        else $error("accept pulse without check");
    chk_done_byte: assert property (security_set_out |-> ##[0:4] !serial_tx_out)
        else $error("completion byte did not start");
    chk_check_once: assert property (pw_check_out |=> !pw_check_out)
        else $error("check held too long");
    chk_string_quiet: assert property (pw_byte_valid_out |-> serial_tx_out [*3])
        else $error("reply during password string");
    chk_idle_silent: assert property (link_idle_out && $past(link_idle_out, 2) |-> serial_tx_out)
        else $error("transmit while idle");
    chk_addr_hold: assert property (pw_byte_valid_out |-> $stable(count_addr_out) && $stable(cmp_addr_out))
        else $error("address moved during string");

    cov_accept: cover property (security_set_out);
    cov_mismatch: cover property (pw_check_out && !pw_match_in);
    cov_blank: cover property (pw_check_out && flash_blank_in);
    cov_idle: cover property ($rose(link_idle_out));
endmodule : bsc_boot_serial_sva

bind bsc_boot_serial bsc_boot_serial_sva #(.CNT_W(CNT_W)) bsc_boot_serial_sva_inst (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .serial_rx_in(serial_rx_in),
    .serial_tx_out(serial_tx_out), .flash_blank_in(flash_blank_in), .pw_len_in(pw_len_in),
    .pw_match_in(pw_match_in), .count_addr_out(count_addr_out), .cmp_addr_out(cmp_addr_out),
    .pw_byte_out(pw_byte_out), .pw_byte_valid_out(pw_byte_valid_out),
    .pw_check_out(pw_check_out), .security_set_out(security_set_out),
    .link_idle_out(link_idle_out));

`default_nettype wire

//--- verification/bsc_ctrl_model.sv
// Behavioural programming controller on the far side of the serial link
`timescale 1ns/10ps
`default_nettype none

module bsc_ctrl_model #(
    parameter int BIT = 8
) (
    // Clock
    input wire logic core_clk_in,
    // Serial pins seen from the controller
    input wire logic dev_tx_in,
    output logic line_out
);
    logic [7:0] rx_q [$];
    logic [7:0] rx_byte;

    initial line_out = 1'h1;

    // One bit time for the detection byte and every later byte
    task automatic send_byte(input logic [7:0] data, input logic stop_bit);
        logic [9:0] frame;
        frame = {stop_bit, data, 1'h0};
        for (int i = 0; i < 10; i++) begin
            @(negedge core_clk_in);
            line_out <= frame[i];
            repeat (BIT - 1) @(negedge core_clk_in);
        end
        @(negedge core_clk_in);
        line_out <= 1'h1;
    endtask : send_byte

    // Samples at bit centres; a missing stop bit is not flagged here
    initial begin
        forever begin
            @(negedge dev_tx_in);
            repeat (BIT / 2) @(posedge core_clk_in);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT) @(posedge core_clk_in);
                rx_byte[i] = dev_tx_in;
            end
            repeat (BIT) @(posedge core_clk_in);
            rx_q.push_back(rx_byte);
        end
    end
endmodule : bsc_ctrl_model

`default_nettype wire

//--- verification/tb_top.sv
// Self-checking bench for the serial boot security interpreter
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    localparam int BIT = 8;
    localparam int GAP = 100;
    logic core_clk_in = 1'h0;
    logic rst_in = 1'h1;
    logic serial_rx_in;
    logic serial_tx_out;
    logic flash_blank_in = 1'h0;
    logic pw_match_in = 1'h0;
    logic [7:0] pw_len_in = 8'h01;
    logic [23:0] count_addr_out;
    logic [23:0] cmp_addr_out;
    logic [7:0] pw_byte_out;
    logic pw_byte_valid_out;
    logic pw_check_out;
    logic security_set_out;
    logic link_idle_out;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    int sets = 0;
    int seed = 32'h5801;
    logic [7:0] exp_q [$];
    logic [7:0] pw_q [$];

    always #5 core_clk_in = ~core_clk_in;

    bsc_boot_serial bsc_boot_serial_inst (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .serial_rx_in(serial_rx_in), .serial_tx_out(serial_tx_out),
        .flash_blank_in(flash_blank_in), .pw_len_in(pw_len_in), .pw_match_in(pw_match_in),
        .count_addr_out(count_addr_out), .cmp_addr_out(cmp_addr_out),
        .pw_byte_out(pw_byte_out), .pw_byte_valid_out(pw_byte_valid_out),
        .pw_check_out(pw_check_out), .security_set_out(security_set_out),
        .link_idle_out(link_idle_out));
    bsc_ctrl_model #(.BIT(BIT)) bsc_ctrl_model_inst (.core_clk_in(core_clk_in),
        .dev_tx_in(serial_tx_out), .line_out(serial_rx_in));

    task automatic wrap_up();
        $display("Checks run %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up

    // Hang guard: sessions need about 30000 cycles
    always @(posedge core_clk_in) begin
        cycles++;
        if (pw_byte_valid_out === 1'h1) begin
            pw_q.push_back(pw_byte_out);
        end
        if (security_set_out === 1'h1) begin
            sets++;
        end
        if (cycles == 90000) begin
            mismatches++;
            wrap_up();
        end
    end

    task automatic cmpv(input string what, input logic [23:0] exp, input logic [23:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmpv

    task automatic cmpn(input string what, input int exp, input int got);
        tests_run++;
        if (got != exp) begin
            mismatches++;
            $display("[ERR] %s expected %0d seen %0d", what, exp, got);
        end
    endtask : cmpn

    // The gap lets each echo finish before the next byte arrives
    task automatic snd(input logic [7:0] data, input logic stop_bit);
        bsc_ctrl_model_inst.send_byte(data, stop_bit);
        repeat (GAP) @(negedge core_clk_in);
    endtask : snd

    // Modes: 0 good, 1 mismatch, 2 blank, 3 bad address frame,
    // 4 unknown command, 5 framed-wrong command, 6 bad second match byte
    task automatic run(input logic [7:0] m1, input logic [7:0] m2, input int mode);
        logic [7:0] addr [6];
        logic [7:0] pw [4];
        logic [7:0] cmd;
        int n;
        @(negedge core_clk_in);
        rst_in = 1'h1;
        repeat (8) @(negedge core_clk_in);
        rst_in = 1'h0;
        repeat (6) @(negedge core_clk_in);
        cmpv("tx after reset", 24'h000001, 24'(serial_tx_out));
        cmpv("idle after reset", 24'h000000, 24'(link_idle_out));
        bsc_ctrl_model_inst.rx_q.delete();
        exp_q.delete();
        pw_q.delete();
        sets = 0;
        n = 1 + ($random(seed) & 3);
        pw_len_in = 8'(n);
        pw_match_in = (mode != 1);
        flash_blank_in = (mode == 2);
        snd(m1, 1'h1);
        exp_q.push_back(m1);
        snd((mode == 6) ? 8'h55 : m2, 1'h1);
        if (mode != 6) exp_q.push_back(m2);
        if (mode == 0) begin
            snd(bsc_pkg::CMD_EMU, 1'h1);
            snd(8'($random(seed)), 1'h1);
            exp_q.push_back(bsc_pkg::CMD_EMU);
            exp_q.push_back(bsc_pkg::EMU_DONE);
        end
        if (mode == 4 || mode == 5) begin
            cmd = (mode == 5) ? bsc_pkg::CMD_SEC : 8'($random(seed));
            if (mode == 4 && (cmd == bsc_pkg::CMD_EMU || cmd == bsc_pkg::CMD_SEC)) cmd = 8'h00;
            snd(cmd, mode == 4);
            repeat (3) exp_q.push_back((mode == 5) ? bsc_pkg::ERR_FRAME : bsc_pkg::ERR_CMD);
        end
        if (mode < 4) begin
            snd(bsc_pkg::CMD_SEC, 1'h1);
            exp_q.push_back(bsc_pkg::CMD_SEC);
            for (int i = 0; i < 6; i++) begin
                addr[i] = 8'($random(seed));
                snd(addr[i], !(mode == 3 && i == 2));
            end
            for (int i = 0; i < n && mode != 3; i++) begin
                pw[i] = 8'($random(seed));
                snd(pw[i], 1'h1);
            end
            if (mode == 0) exp_q.push_back(bsc_pkg::SEC_DONE);
        end
        snd(bsc_pkg::CMD_EMU, 1'h1);
        snd(8'h5A, 1'h1);
        if (mode == 0) exp_q.push_back(bsc_pkg::CMD_EMU);
        if (mode == 0) exp_q.push_back(bsc_pkg::EMU_DONE);
        repeat (300) @(negedge core_clk_in);
        cmpn("reply count", exp_q.size(), bsc_ctrl_model_inst.rx_q.size());
        for (int i = 0; i < exp_q.size() && i < bsc_ctrl_model_inst.rx_q.size(); i++) begin
            cmpv("reply byte", 24'(exp_q[i]), 24'(bsc_ctrl_model_inst.rx_q[i]));
        end
        cmpv("idle", 24'(mode != 0), 24'(link_idle_out));
        cmpn("accept pulses", (mode == 0) ? 1 : 0, sets);
        if (mode < 3) begin
            cmpv("count address", {addr[0], addr[1], addr[2]}, count_addr_out);
            cmpv("compare address", {addr[3], addr[4], addr[5]}, cmp_addr_out);
            cmpn("string length", n, pw_q.size());
            for (int i = 0; i < n && i < pw_q.size(); i++) begin
                cmpv("string byte", 24'(pw[i]), 24'(pw_q[i]));
            end
        end
    endtask : run

    initial begin
        for (int r = 0; r < 2; r++) begin
            for (int m = 0; m < 7; m++) begin
                run((m[0] ^ r[0]) ? bsc_pkg::MATCH1_B : bsc_pkg::MATCH1_A,
                    m[1] ? bsc_pkg::MATCH2_B : bsc_pkg::MATCH2_A, m);
            end
        end
        wrap_up();
    end
endmodule : tb_top

`default_nettype wire
